// ==== verilog/ida_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module ida_core
  import ida_pkg::*;
#(
  parameter int PM_WORDS = 2048
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // external program memory
  input wire logic [15:0] ext_rdata,
  output logic [15:0] ext_addr,
  output logic [15:0] ext_wdata,
  output logic ext_we,
  output logic ext_re
);
  localparam int PM_AW = $clog2(PM_WORDS);

  // a 64k-word internal space would overflow the 16-bit address compare
  generate
    if (PM_WORDS < 2 || PM_WORDS > 32768 || (PM_WORDS & (PM_WORDS - 1)) != 0)
    begin : g_bad_pm
      $error("PM_WORDS must be a power of two from 2 to 32768");
    end
  endgenerate

  logic awready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] ptr_a_r, ptr_b_r, alu_r, tbl_lo_r, tbl_hi_r;
  logic [BANK_W-1:0] bank_r;
  logic [1:0] mode_r;
  logic [15:0] latch_r;
  logic [8:0] res_r;
  logic [15:0] ext_s1_r, ext_s2_r, ext_addr_r, ext_wdata_r;
  logic ext_we_r, ext_re_r;
  logic [7:0] dmem [DM_WORDS];
  logic [15:0] pmem [PM_WORDS];
  logic [15:0] cfgmem [2**CFG_AW];

  function automatic logic [DM_AW-1:0] dm_index(input logic [7:0] a, input logic [BANK_W-1:0] b);
    logic [7:0] off;
    off = a - BANK_LO;
    if (a >= BANK_LO && a <= BANK_HI)
      return DM_BANK_BASE + DM_AW'({b, off[SPAN_W-1:0]});
    return DM_AW'(a);
  endfunction

  function automatic logic [7:0] ptr_step(input logic [7:0] p, input logic [1:0] c);
    if (c == CTL_INC)
      return p + 8'h01;
    if (c == CTL_DEC)
      return p - 8'h01;
    return p;
  endfunction

  // handshakes; reads and writes never complete in the same cycle
  wire wr_hs = awready_r && awvalid && wvalid;
  wire rd_hs = arready_r && arvalid;
  wire start_wr = awvalid && wvalid && !awready_r && !bvalid_r && !arready_r;
  wire start_rd = arvalid && !arready_r && !rvalid_r && !awready_r && !start_wr;
  wire lane0 = wstrb[0];

  // indirect access decode
  wire [7:0] acc_addr = wr_hs ? awaddr : araddr;
  wire acc = (wr_hs && lane0) || rd_hs; // a write with no byte lane is a no-op and does not step the pointer
  wire acc_a = acc && acc_addr == REG_PORT_A;
  wire acc_b = acc && acc_addr == REG_PORT_B;
  wire [1:0] ctl_a = alu_r[ALU_CTL_A +: 2];
  wire [1:0] ctl_b = alu_r[ALU_CTL_B +: 2];
  wire [7:0] ind_ptr = acc_b ? ptr_b_r : ptr_a_r;
  wire ind_null = ind_ptr == DM_PORT_A || ind_ptr == DM_PORT_B;
  wire [DM_AW-1:0] ind_idx = dm_index(ind_ptr, bank_r);
  wire [7:0] ind_rd = ind_null ? 8'h00 : dmem[ind_idx];
  wire ind_wr = wr_hs && lane0 && (acc_a || acc_b) && !ind_null;
  wire ind_rdz = rd_hs && (acc_a || acc_b) && ind_null;

  // table access decode
  wire [15:0] tbl_addr = {tbl_hi_r, tbl_lo_r};
  wire tbl_cmd = wr_hs && lane0 && awaddr == REG_TBL_CMD;
  wire [1:0] op = wdata[1:0];
  wire hib = wdata[CMD_HIB];
  wire [7:0] op_data = wdata[CMD_DATA +: 8];
  wire is_cfg = tbl_addr >= CFG_BASE;
  wire is_int = tbl_addr < 16'(PM_WORDS);
  wire ext_ok = mode_r == MODE_MP || mode_r == MODE_EMC;
  wire int_ok = mode_r != MODE_MP;
  wire cfg_ok = mode_r == MODE_MC || mode_r == MODE_PROT;
  wire tgt_cfg = is_cfg && cfg_ok;
  wire tgt_int = !is_cfg && is_int && int_ok;
  wire tgt_ext = !is_cfg && ext_ok && !(is_int && int_ok);
  wire blocked = !(tgt_cfg || tgt_int || tgt_ext);
  wire [15:0] pm_rd = tgt_int ? pmem[tbl_addr[PM_AW-1:0]] :
                      tgt_cfg ? cfgmem[tbl_addr[CFG_AW-1:0]] :
                      tgt_ext ? ext_s2_r : 16'h0000;
  wire [7:0] latch_byte = hib ? latch_r[15:8] : latch_r[7:0];
  wire [15:0] latch_new = hib ? {op_data, latch_r[7:0]} : {latch_r[15:8], op_data};
  wire tbl_wr = tbl_cmd && op == OP_TBL_WR;
  wire [15:0] tbl_ptr_nxt = (tbl_cmd && op[1] && wdata[CMD_INC]) ? tbl_addr + 16'h0001 : tbl_addr;

  // register read mux; the latch has no address of its own
  wire hit = acc_addr == REG_PORT_A || acc_addr == REG_PORT_B || acc_addr == REG_PTR_A ||
             acc_addr == REG_PTR_B || acc_addr == REG_BANK || acc_addr == REG_ALU ||
             acc_addr == REG_TBL_LO || acc_addr == REG_TBL_HI || acc_addr == REG_MODE ||
             acc_addr == REG_TBL_CMD || acc_addr == REG_TBL_RES;
  wire [31:0] rd_val = (acc_a || acc_b) ? {24'h000000, ind_rd} :
                       araddr == REG_PTR_A ? {24'h000000, ptr_a_r} :
                       araddr == REG_PTR_B ? {24'h000000, ptr_b_r} :
                       araddr == REG_BANK ? {28'h0000000, bank_r} :
                       araddr == REG_ALU ? {24'h000000, alu_r} :
                       araddr == REG_TBL_LO ? {24'h000000, tbl_lo_r} :
                       araddr == REG_TBL_HI ? {24'h000000, tbl_hi_r} :
                       araddr == REG_MODE ? {30'h00000000, mode_r} :
                       araddr == REG_TBL_RES ? {23'h000000, res_r} : 32'h00000000;

  // status: apart from a direct write of REG_ALU, only the null-read case touches the zero flag
  wire [7:0] alu_nxt = (wr_hs && lane0 && awaddr == REG_ALU) ? (wdata[7:0] & ALU_WMASK) :
                       ind_rdz ? (alu_r | (8'h01 << ALU_Z)) : alu_r;
  wire [7:0] ptr_a_nxt = (wr_hs && lane0 && awaddr == REG_PTR_A) ? wdata[7:0] :
                         acc_a ? ptr_step(ptr_a_r, ctl_a) : ptr_a_r;
  wire [7:0] ptr_b_nxt = (wr_hs && lane0 && awaddr == REG_PTR_B) ? wdata[7:0] :
                         acc_b ? ptr_step(ptr_b_r, ctl_b) : ptr_b_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      awready_r <= start_wr;
      arready_r <= start_rd;
      bvalid_r <= wr_hs || (bvalid_r && !bready);
      rvalid_r <= rd_hs || (rvalid_r && !rready);
      if (wr_hs)
        bresp_r <= hit ? RESP_OKAY : RESP_SLVERR;
      if (rd_hs)
      begin
        rresp_r <= hit ? RESP_OKAY : RESP_SLVERR;
        rdata_r <= rd_val;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr_a_r <= 8'h00;
      ptr_b_r <= 8'h00;
      alu_r <= ALU_RESET;
      bank_r <= '0;
      tbl_lo_r <= 8'h00;
      tbl_hi_r <= 8'h00;
      mode_r <= MODE_MP;
    end
    else
    begin
      ptr_a_r <= ptr_a_nxt;
      ptr_b_r <= ptr_b_nxt;
      alu_r <= alu_nxt;
      {tbl_hi_r, tbl_lo_r} <= tbl_ptr_nxt;
      if (wr_hs && lane0 && awaddr == REG_TBL_LO)
        tbl_lo_r <= wdata[7:0];
      if (wr_hs && lane0 && awaddr == REG_TBL_HI)
        tbl_hi_r <= wdata[7:0];
      if (wr_hs && lane0 && awaddr == REG_BANK)
        bank_r <= wdata[BANK_W-1:0];
      if (wr_hs && lane0 && awaddr == REG_MODE)
        mode_r <= wdata[1:0];
    end
  end

  // table latch and the four transfer operations
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latch_r <= 16'h0000;
      res_r <= 9'h000;
      ext_we_r <= 1'b0;
      ext_re_r <= 1'b0;
      ext_addr_r <= 16'h0000;
      ext_wdata_r <= 16'h0000;
    end
    else
    begin
      ext_we_r <= tbl_wr && tgt_ext;
      ext_re_r <= tbl_cmd && op == OP_TBL_RD && tgt_ext;
      // address tracks the pointer so external read data settles before a table read
      ext_addr_r <= tbl_addr;
      if (tbl_cmd)
      begin
        case (op)
          OP_LATCH_RD: res_r <= {1'b0, latch_byte};
          OP_LATCH_WR: latch_r <= latch_new;
          OP_TBL_RD:
          begin
            res_r <= {blocked, latch_byte};
            latch_r <= pm_rd;
          end
          OP_TBL_WR:
          begin
            res_r <= {blocked, 8'h00};
            latch_r <= latch_new;
            ext_wdata_r <= latch_new;
          end
          default: res_r <= res_r;
        endcase
      end
    end
  end

  // external read data is sampled twice before use; it must be stable
  always_ff @(posedge aclk)
  begin
    ext_s1_r <= ext_rdata;
    ext_s2_r <= ext_s1_r;
  end

  // memories carry no reset
  always_ff @(posedge aclk)
  begin
    if (ind_wr)
      dmem[ind_idx] <= wdata[7:0];
    if (tbl_wr && tgt_int)
      pmem[tbl_addr[PM_AW-1:0]] <= latch_new;
    if (tbl_wr && tgt_cfg)
      cfgmem[tbl_addr[CFG_AW-1:0]] <= latch_new;
  end

  assign awready = awready_r;
  assign wready = awready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign ext_addr = ext_addr_r;
  assign ext_wdata = ext_wdata_r;
  assign ext_we = ext_we_r;
  assign ext_re = ext_re_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_port_a_read;
    rd_hs && acc_a;
  endsequence

  sequence s_null_read;
    rd_hs && (acc_a || acc_b) && ind_null;
  endsequence

  chk_ptr_inc: assert property (s_port_a_read and ctl_a == CTL_INC |=> ptr_a_r == $past(ptr_a_r) + 8'h01)
    else $error("pointer a did not increment");
  chk_ptr_dec: assert property (rd_hs && acc_b && ctl_b == CTL_DEC |=> ptr_b_r == $past(ptr_b_r) - 8'h01)
    else $error("pointer b did not decrement");
  chk_null_read_zero: assert property (s_null_read |=> rvalid_r && rdata_r == 32'h0 && alu_r[ALU_Z])
    else $error("null indirect read not zero with zero flag");
  chk_null_write_nop: assert property (wr_hs && (acc_a || acc_b) && ind_null |=> alu_r == $past(alu_r))
    else $error("null indirect write changed status");
  chk_update_no_flag: assert property (rd_hs && (acc_a || acc_b) && !ind_null |=> alu_r == $past(alu_r))
    else $error("pointer update changed status");
  chk_read_old_ptr: assert property (s_port_a_read and !ind_null |=> rdata_r[7:0] == $past(ind_rd))
    else $error("indirect read did not use old pointer");
  chk_read_one_cycle: assert property (start_rd ##1 rd_hs |=> rvalid_r)
    else $error("indirect read not answered in one cycle");
  chk_mode_reset: assert property ($rose(aresetn) |-> mode_r == MODE_MP)
    else $error("mode not microprocessor after reset");
  chk_ext_gate: assert property (ext_we_r |-> $past(mode_r) == MODE_MP || $past(mode_r) == MODE_EMC)
    else $error("external write outside mp or emc mode");
  chk_latch_byte: assert property (tbl_cmd && op == OP_LATCH_WR && !hib |=>
                                   latch_r == {$past(latch_r[15:8]), $past(wdata[15:8])})
    else $error("latch low byte write wrong");

  // table checks look one cycle after the command edge
  sequence s_table_read;
    tbl_cmd && op == OP_TBL_RD;
  endsequence

  chk_ptr_b_inc: assert property (acc_b && ctl_b == CTL_INC |=> ptr_b_r == $past(ptr_b_r) + 8'h01)
    else $error("pointer b did not increment");
  chk_ptr_hold: assert property (acc_a && ctl_a[1] |=> ptr_a_r == $past(ptr_a_r))
    else $error("pointer a moved with hold control");
  chk_mp_ext_write: assert property (tbl_wr && mode_r == MODE_MP && !is_cfg |=> ext_we_r && ext_addr_r == $past(tbl_addr))
    else $error("microprocessor mode table write not external");
  chk_cfg_emc_block: assert property (s_table_read ##0 is_cfg && mode_r == MODE_EMC |=> res_r[RES_BLOCKED])
    else $error("configuration area reachable in extended mode");
  chk_mc_no_ext: assert property (tbl_cmd && op[1] && mode_r == MODE_MC && !is_cfg && !is_int |=>
                                  res_r[RES_BLOCKED] && !ext_we_r && !ext_re_r)
    else $error("table access left the chip in microcontroller mode");
  chk_tbl_ptr_step: assert property (tbl_cmd && op[1] && wdata[CMD_INC] |=> {tbl_hi_r, tbl_lo_r} == $past(tbl_addr) + 16'h0001)
    else $error("table pointer did not step");
endmodule
`default_nettype wire

// ==== verilog/ida_pkg.sv ====
`default_nettype none
package ida_pkg;
  // axi register byte offsets
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_PORT_A = 8'h00;
  localparam logic [7:0] REG_PORT_B = 8'h04;
  localparam logic [7:0] REG_PTR_A = 8'h08;
  localparam logic [7:0] REG_PTR_B = 8'h0c;
  localparam logic [7:0] REG_BANK = 8'h10;
  localparam logic [7:0] REG_ALU = 8'h14;
  localparam logic [7:0] REG_TBL_LO = 8'h18;
  localparam logic [7:0] REG_TBL_HI = 8'h1c;
  localparam logic [7:0] REG_MODE = 8'h20;
  localparam logic [7:0] REG_TBL_CMD = 8'h24;
  localparam logic [7:0] REG_TBL_RES = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // data memory map
  localparam logic [7:0] DM_PORT_A = 8'h00;
  localparam logic [7:0] DM_PORT_B = 8'h08;
  localparam logic [7:0] BANK_LO = 8'h10;
  localparam logic [7:0] BANK_HI = 8'h17;
  localparam int BANK_W = 4;
  localparam int SPAN_W = 3;
  localparam int DM_AW = 9;
  localparam int DM_WORDS = 384;
  localparam logic [DM_AW-1:0] DM_BANK_BASE = 9'h100;
  // alu status layout
  localparam int ALU_CTL_B = 6;
  localparam int ALU_CTL_A = 4;
  localparam int ALU_Z = 2;
  localparam logic [7:0] ALU_WMASK = 8'hf4;
  localparam logic [7:0] ALU_RESET = 8'hf0;
  localparam logic [1:0] CTL_DEC = 2'h0;
  localparam logic [1:0] CTL_INC = 2'h1;
  // operating modes, erased configuration reads as all ones
  localparam logic [1:0] MODE_MP = 2'h3;
  localparam logic [1:0] MODE_MC = 2'h2;
  localparam logic [1:0] MODE_EMC = 2'h1;
  localparam logic [1:0] MODE_PROT = 2'h0;
  // table command layout and opcodes
  localparam int CMD_HIB = 2;
  localparam int CMD_INC = 3;
  localparam int CMD_DATA = 8;
  localparam int RES_BLOCKED = 8;
  localparam logic [1:0] OP_LATCH_RD = 2'h0;
  localparam logic [1:0] OP_LATCH_WR = 2'h1;
  localparam logic [1:0] OP_TBL_RD = 2'h2;
  localparam logic [1:0] OP_TBL_WR = 2'h3;
  // configuration, test and boot area of program space
  localparam logic [15:0] CFG_BASE = 16'hfe00;
  localparam int CFG_AW = 4;
endpackage
`default_nettype wire

// ==== sim/ida_pm_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// external program memory on the far side of the table path
// only 16 words are kept, so addresses alias on their low four bits
module ida_pm_model (
  // clock
  input wire logic aclk,
  // program memory bus
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_wdata,
  input wire logic ext_we,
  output logic [15:0] ext_rdata
);
  logic [15:0] mem [16];
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 16'hc000 | 16'(i);
  end
  always @(posedge aclk)
  begin
    if (ext_we === 1'b1)
      mem[ext_addr[3:0]] <= ext_wdata;
  end
  // read data follows the held address, so it is settled well before the next read
  assign ext_rdata = mem[ext_addr[3:0]];
endmodule
`default_nettype wire

// ==== sim/indirect_data_addressing_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module indirect_data_addressing_tb;
  import ida_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, ext_we, ext_re;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] ext_rdata, ext_addr, ext_wdata;
  int bad_count = 0, samples_checked = 0, we_cnt = 0, re_cnt = 0;
  always #2.5 aclk = ~aclk;
  always_ff @(posedge aclk)
  begin
    if (ext_we === 1'b1)
      we_cnt <= we_cnt + 1;
    if (ext_re === 1'b1)
      re_cnt <= re_cnt + 1;
  end
  ida_core #(.PM_WORDS(2048)) i_ida_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_rdata(ext_rdata), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_we(ext_we), .ext_re(ext_re));
  ida_pm_model i_ida_pm_model (.aclk(aclk), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_we(ext_we),
    .ext_rdata(ext_rdata));
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lim(input int n);
    if (n >= 50)
    begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 && ++n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1 && ++n < 50);
    bready <= 1'b0;
    lim(n);
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY,
    input logic [31:0] m = 32'hffffffff);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1 && ++n < 50);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1 && ++n < 50);
    rready <= 1'b0;
    lim(n);
    chk(32'(rresp), 32'(er));
    chk(rdata & m, e);
    @(posedge aclk);
  endtask
  // table command: data byte, increment, high byte select, opcode
  task automatic cmd(input logic [1:0] op, input logic hi, input logic [7:0] d, input logic inc = 1'b0);
    wr(REG_TBL_CMD, {16'h0, d, 4'h0, inc, hi, op});
  endtask
  task automatic tptr(input logic [15:0] p);
    wr(REG_TBL_HI, 32'(p[15:8]));
    wr(REG_TBL_LO, 32'(p[7:0]));
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_ALU, 32'hf0);
    rd(REG_MODE, 32'(MODE_MP));
    rd(REG_PTR_A, 32'h0);
    rd(8'h2c, 32'h0, RESP_SLVERR);
    wr(8'h2c, 32'h1, RESP_SLVERR);
    $display("reset and map test done");
    wr(REG_ALU, 32'hd0);
    wr(REG_PTR_A, 32'h20);
    wr(REG_PORT_A, 32'h5a);
    rd(REG_PTR_A, 32'h21);
    wr(REG_PORT_A, 32'h6b);
    wr(REG_ALU, 32'hc0);
    wr(REG_PTR_A, 32'h21);
    rd(REG_PORT_A, 32'h6b);
    rd(REG_PORT_A, 32'h5a);
    rd(REG_PTR_A, 32'h1f);
    wr(REG_ALU, 32'hd0);
    wr(REG_PTR_A, 32'hff);
    wr(REG_PORT_A, 32'h77);
    rd(REG_PTR_A, 32'h0);
    rd(REG_ALU, 32'hd0);
    rd(REG_PORT_A, 32'h0);
    rd(REG_ALU, 32'hd4);
    wr(REG_ALU, 32'hf0);
    wr(REG_PTR_A, 32'h0);
    wr(REG_PORT_A, 32'h99);
    rd(REG_ALU, 32'hf0);
    wr(REG_PTR_B, 32'(DM_PORT_B));
    rd(REG_PORT_B, 32'h0);
    rd(REG_ALU, 32'hf4);
    wr(REG_ALU, 32'hf0);
    wr(REG_PORT_B, 32'h55);
    rd(REG_ALU, 32'hf0);
    wr(REG_PTR_B, 32'h12);
    for (int b = 1; b < 3; b++)
    begin
      wr(REG_BANK, 32'(b));
      wr(REG_PORT_B, 32'(b * 17));
    end
    wr(REG_BANK, 32'h1);
    rd(REG_PORT_B, 32'h11);
    wr(REG_BANK, 32'h2);
    rd(REG_PORT_B, 32'h22);
    wr(REG_ALU, 32'h70);
    wr(REG_PTR_A, 32'h40);
    wr(REG_PTR_B, 32'h40);
    wr(REG_PORT_B, 32'h3c);
    rd(REG_PTR_B, 32'h41);
    rd(REG_PTR_A, 32'h40);
    wr(REG_ALU, 32'h30);
    wr(REG_PTR_B, 32'h40);
    rd(REG_PORT_B, 32'h3c);
    rd(REG_PTR_B, 32'h3f);
    $display("indirect test done");
    wr(REG_MODE, 32'(MODE_MC));
    tptr(16'h0005);
    cmd(OP_LATCH_WR, 1'b1, 8'h12);
    cmd(OP_TBL_WR, 1'b0, 8'h34);
    cmd(OP_LATCH_WR, 1'b0, 8'h00);
    cmd(OP_LATCH_WR, 1'b1, 8'h00);
    cmd(OP_TBL_RD, 1'b0, 8'h00, 1'b1);
    rd(REG_TBL_RES, 32'h0);
    rd(REG_TBL_LO, 32'h6);
    cmd(OP_LATCH_RD, 1'b1, 8'h00);
    rd(REG_TBL_RES, 32'h12);
    cmd(OP_LATCH_RD, 1'b0, 8'h00);
    rd(REG_TBL_RES, 32'h34);
    chk(32'(we_cnt), 32'h0);
    // high byte of the pointer matters: beyond internal memory, not reachable here
    tptr(16'h0900);
    cmd(OP_TBL_WR, 1'b0, 8'h56);
    rd(REG_TBL_RES, 32'h100, RESP_OKAY, 32'h100);
    wr(REG_MODE, 32'(MODE_EMC));
    cmd(OP_TBL_WR, 1'b0, 8'h56);
    chk(32'(we_cnt), 32'h1);
    chk(32'(ext_addr), 32'h0900);
    chk(32'(ext_wdata), 32'h1256);
    wr(REG_MODE, 32'(MODE_MP));
    tptr(16'h0005);
    cmd(OP_TBL_WR, 1'b1, 8'hab);
    chk(32'(we_cnt), 32'h2);
    repeat (3) @(posedge aclk);
    cmd(OP_TBL_RD, 1'b0, 8'h00);
    cmd(OP_LATCH_RD, 1'b1, 8'h00);
    rd(REG_TBL_RES, 32'hab);
    chk(32'(re_cnt), 32'h1);
    for (int m = 0; m < 4; m++)
    begin
      wr(REG_MODE, 32'(m));
      tptr(CFG_BASE);
      cmd(OP_TBL_RD, 1'b0, 8'h00);
      rd(REG_TBL_RES, (m == MODE_MP || m == MODE_EMC) ? 32'h100 : 32'h0, RESP_OKAY, 32'h100);
      tptr(16'h0010);
      cmd(OP_TBL_RD, 1'b0, 8'h00);
      rd(REG_TBL_RES, 32'h0, RESP_OKAY, 32'h100);
    end
    // last external read came from address 0x0010, which aliases onto the word written at 0x0900
    cmd(OP_LATCH_RD, 1'b1, 8'h00);
    rd(REG_TBL_RES, 32'h12);
    chk(32'(re_cnt), 32'h2);
    $display("table test done");
    stop_test();
  end
endmodule
`default_nettype wire
